/* File: rtl/cspr_defines.svh */
// Constants for the stack pointer, program counter and flags block.
// Assumes a byte-wide memory port driven by this block, with requests from the core sequencer.
`ifndef CSPR_DEFINES_SVH
`define CSPR_DEFINES_SVH
`define CSPR_SP_RESET 16'h00ff
`define CSPR_SPL_RELOAD 8'hff
`define CSPR_VEC_HI_ADDR 16'hfffe
`define CSPR_VEC_LO_ADDR 16'hffff
`define CSPR_CCR_ONES 8'h60
`define CSPR_OP_STACK_LOW_RELOAD 8'h9c
`define CSPR_OP_INTERRUPT_RETURN 8'h80
`define CSPR_RTI_CYCLES 4'h9
`endif

/* File: rtl/cspr_pkg.sv */
// Types for the stack pointer, program counter and flags block.
// Assumes cspr_defines.svh is on the include path.
`default_nettype none
package cspr_pkg;
   typedef enum logic [6:0] {
      ST_VEC_HI = 7'h01,
      ST_VEC_LO = 7'h02,
      ST_RUN    = 7'h04,
      ST_PUSH   = 7'h08,
      ST_PULL   = 7'h10,
      ST_PULL_W = 7'h20,
      ST_IDLE   = 7'h40
   } cspr_state_t;

   // Operation request from the sequencer
   typedef struct packed {
      logic fetch;          // Byte fetched at program_counter
      logic load;           // Change of flow to target
      logic [15:0] target;
      logic adjust;         // stack_adjust_op
      logic [7:0] adjust_imm;
      logic low_reload;     // stack_low_reload_op
      logic irq_entry;      // Begin interrupt push sequence
      logic [15:0] isr_addr;
      logic irq_return;     // interrupt_return_op
      logic ccr_wr;
      logic [7:0] ccr_in;
      logic [7:0] acc_in;
      logic [7:0] idx_in;
   } cspr_req_t;

   // Memory byte port
   typedef struct packed {
      logic rd;
      logic wr;
      logic [15:0] addr;
      logic [7:0] wdata;
   } cspr_mem_t;

   typedef struct packed {
      cspr_state_t st;
      logic [15:0] stack_pointer;
      logic [15:0] program_counter;
      logic [7:0] condition_flags_reg;
      logic [7:0] acc;
      logic [7:0] idx;
      logic [2:0] cnt;
      logic [3:0] cyc;
      logic valid_acc;
      logic valid_idx;
      cspr_mem_t mem;
   } cspr_regs_t;
endpackage
`default_nettype wire

/* File: rtl/cspr_core_regs.sv */
// Stack pointer, program counter and condition flags with stacking sequences.
// Assumes memory read data returns in the cycle after a read strobe.
`include "cspr_defines.svh"
`default_nettype none
module cspr_core_regs (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire cspr_pkg::cspr_req_t req,
   input wire logic [7:0] mem_rdata,
   output cspr_pkg::cspr_mem_t mem,
   output logic [15:0] stack_pointer,
   output logic [15:0] program_counter,
   output logic [7:0] condition_flags_reg,
   output logic [7:0] acc_out,
   output logic acc_valid,
   output logic [7:0] idx_out,
   output logic idx_valid,
   output logic busy
);
   import cspr_pkg::*;

   cspr_regs_t r_q, r_d;

   // Next state of every register
   always_comb begin
      r_d = r_q;
      r_d.mem = '0;
      r_d.valid_acc = 1'b0;
      r_d.valid_idx = 1'b0;
      unique case (r_q.st)
         ST_IDLE: begin
            // Vector high byte at lower address
            r_d.mem.rd = 1'b1;
            r_d.mem.addr = `CSPR_VEC_HI_ADDR;
            r_d.st = ST_VEC_HI;
         end
         ST_VEC_HI: begin
            r_d.mem.rd = 1'b1;
            r_d.mem.addr = `CSPR_VEC_LO_ADDR;
            r_d.st = ST_VEC_LO;
         end
         ST_VEC_LO: begin
            r_d.program_counter[15:8] = mem_rdata;
            r_d.st = ST_PULL_W;
            r_d.cnt = 3'h7;
         end
         ST_RUN: begin
            if (req.irq_entry) begin
               // Begin push of return address and registers
               r_d.acc = req.acc_in;
               r_d.idx = req.idx_in;
               r_d.cnt = 3'h0;
               r_d.st = ST_PUSH;
            end else if (req.irq_return) begin
               r_d.cnt = 3'h0;
               r_d.cyc = `CSPR_RTI_CYCLES - 4'h1;
               r_d.stack_pointer = r_q.stack_pointer + 16'h0001;
               r_d.mem.rd = 1'b1;
               r_d.mem.addr = r_q.stack_pointer + 16'h0001;
               r_d.st = ST_PULL;
            end else begin
               if (req.load) begin
                  r_d.program_counter = req.target;
               end else if (req.fetch) begin
                  r_d.program_counter = r_q.program_counter + 16'h0001;
               end
               if (req.adjust) begin
                  // Sign-extended add
                  r_d.stack_pointer = r_q.stack_pointer + {{8{req.adjust_imm[7]}}, req.adjust_imm};
               end else if (req.low_reload) begin
                  r_d.stack_pointer[7:0] = `CSPR_SPL_RELOAD;
               end
               if (req.ccr_wr) begin
                  r_d.condition_flags_reg = req.ccr_in | `CSPR_CCR_ONES;
               end
            end
         end
         ST_PUSH: begin
            // Write then post-decrement, low return byte first
            r_d.mem.wr = 1'b1;
            r_d.mem.addr = r_q.stack_pointer;
            unique case (r_q.cnt)
               3'h0: r_d.mem.wdata = r_q.program_counter[7:0];
               3'h1: r_d.mem.wdata = r_q.program_counter[15:8];
               3'h2: r_d.mem.wdata = r_q.idx;
               3'h3: r_d.mem.wdata = r_q.acc;
               default: r_d.mem.wdata = r_q.condition_flags_reg;
            endcase
            r_d.stack_pointer = r_q.stack_pointer - 16'h0001;
            r_d.cnt = r_q.cnt + 3'h1;
            if (r_q.cnt == 3'h4) begin
               r_d.program_counter = req.isr_addr;
               r_d.st = ST_RUN;
            end
         end
         ST_PULL: begin
            // Wait one cycle for the read data; capture and the next pull's pre-increment happen in ST_PULL_W
            r_d.cyc = r_q.cyc - 4'h1;
            r_d.st = ST_PULL_W;
         end
         ST_PULL_W: begin
            if (r_q.cnt == 3'h7) begin
               r_d.program_counter[7:0] = mem_rdata; // Vector low byte
               r_d.st = ST_RUN;
            end else begin
               unique case (r_q.cnt)
                  3'h0: r_d.condition_flags_reg = mem_rdata | `CSPR_CCR_ONES;
                  3'h1: begin
                     r_d.acc = mem_rdata;
                     r_d.valid_acc = 1'b1;
                  end
                  3'h2: begin
                     r_d.idx = mem_rdata;
                     r_d.valid_idx = 1'b1;
                  end
                  3'h3: r_d.program_counter[15:8] = mem_rdata;
                  default: r_d.program_counter[7:0] = mem_rdata;
               endcase
               r_d.cyc = (r_q.cyc == 4'h0) ? 4'h0 : r_q.cyc - 4'h1;
               if (r_q.cnt == 3'h4) begin
                  r_d.st = ST_RUN;
               end else begin
                  r_d.cnt = r_q.cnt + 3'h1;
                  r_d.stack_pointer = r_q.stack_pointer + 16'h0001;
                  r_d.mem.rd = 1'b1;
                  r_d.mem.addr = r_q.stack_pointer + 16'h0001;
                  r_d.st = ST_PULL;
               end
            end
         end
         default: r_d.st = ST_IDLE;
      endcase
   end

   // State register, reset value 00FF on stack pointer
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         r_q <= '0;
         r_q.st <= ST_IDLE;
         r_q.stack_pointer <= `CSPR_SP_RESET;
         r_q.condition_flags_reg <= `CSPR_CCR_ONES;
      end else begin
         r_q <= r_d;
      end
   end

   // Outputs from registers
   assign mem = r_q.mem;
   assign stack_pointer = r_q.stack_pointer;
   assign program_counter = r_q.program_counter; // Next fetch address
   assign condition_flags_reg = r_q.condition_flags_reg;
   assign acc_out = r_q.acc;
   assign idx_out = r_q.idx;
   assign acc_valid = r_q.valid_acc;
   assign idx_valid = r_q.valid_idx;
   assign busy = (r_q.st != ST_RUN);

   // Checks on the registered outputs and the stacking sequences

   // Stack pointer holds 00ff in the cycle after every reset edge
   a_sp_reset: assert property (
      @(posedge core_clk) sys_rst |=> stack_pointer == `CSPR_SP_RESET)
      else $error("stack pointer not 00ff after reset");

   // Memory port stays quiet while reset is applied
   a_rst_idle: assert property (
      @(posedge core_clk) sys_rst |=> !mem.rd && !mem.wr)
      else $error("memory strobe during reset");

   // Fixed ones in the flags register
   a_ccr_ones: assert property (
      @(posedge core_clk) disable iff (sys_rst) condition_flags_reg[6:5] == 2'b11)
      else $error("flag bits 6:5 not one");

   // Sequential fetch advances the program counter by one
   a_pc_incr: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      (r_q.st == ST_RUN && req.fetch && !req.load && !req.irq_entry && !req.irq_return)
      |=> program_counter == $past(program_counter) + 16'h0001)
      else $error("pc did not increment");

   // Change of flow takes the target as given
   a_pc_load: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      (r_q.st == ST_RUN && req.load && !req.irq_entry && !req.irq_return)
      |=> program_counter == $past(req.target))
      else $error("pc did not load target");

   // Adjust adds the sign-extended immediate to the whole pointer
   a_sp_adjust: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      (r_q.st == ST_RUN && req.adjust && !req.irq_entry && !req.irq_return)
      |=> stack_pointer ==
      $past(stack_pointer) + {{8{$past(req.adjust_imm[7])}}, $past(req.adjust_imm)})
      else $error("stack adjust wrong");

   // Low reload touches only the low byte
   a_sp_reload: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      (r_q.st == ST_RUN && req.low_reload && !req.adjust && !req.irq_entry && !req.irq_return)
      |=> stack_pointer == {$past(stack_pointer[15:8]), `CSPR_SPL_RELOAD})
      else $error("low reload wrong");

   // Vector read goes out one cycle after reset ends, high byte address first
   a_vec_fetch: assert property (
      @(posedge core_clk) $fell(sys_rst)
      |=> (mem.rd && mem.addr == `CSPR_VEC_HI_ADDR)
      ##1 (mem.rd && mem.addr == `CSPR_VEC_LO_ADDR))
      else $error("reset vector fetch wrong");

   // First push puts the low return byte at the old stack pointer
   a_push_first: assert property (
      @(posedge core_clk) disable iff (sys_rst) (r_q.st == ST_RUN && req.irq_entry)
      |=> ##1 (mem.wr && mem.addr == $past(stack_pointer, 2)
      && mem.wdata == $past(program_counter[7:0], 2)))
      else $error("first push wrong");

   // Five pushes move the pointer down by five
   a_push_len: assert property (
      @(posedge core_clk) disable iff (sys_rst) (r_q.st == ST_RUN && req.irq_entry)
      |=> ##5 stack_pointer == $past(stack_pointer, 6) - 16'h0005)
      else $error("push did not move sp by five");

   // Five pulls, each a read and a wait, end with the pointer up by five
   a_pull_len: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      (r_q.st == ST_RUN && req.irq_return && !req.irq_entry)
      |=> busy [*8] ##1 busy [*2] ##1
      (r_q.st == ST_RUN && stack_pointer == $past(stack_pointer, 11) + 16'h0005))
      else $error("return did not finish in time");
endmodule
`default_nettype wire

/* File: verification/cpu_stack_pc_ccr_regs_test.sv */
// Self-checking bench for the stack pointer, program counter and flags block.
// Assumes the bench plays both sequencer and byte memory, 25 MHz core clock.
`include "cspr_defines.svh"
`default_nettype none
`define CSPR_CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin fail_count++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module cpu_stack_pc_ccr_regs_test;
   import cspr_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   cspr_req_t req;
   logic [7:0] mem_rdata, acc_out, idx_out, condition_flags_reg, v, e8, x8;
   cspr_mem_t mem;
   logic [15:0] stack_pointer, program_counter, sp, pc, e16, rd_addr;
   logic [7:0] v_tab [4] = '{8'h7f, 8'h7f, 8'h80, 8'h05};
   logic acc_valid, idx_valid, busy, rd_seen;
   logic [23:0] e24;
   int fail_count = 0;
   int samples_checked = 0;
   logic [7:0] ram [0:65535];
   logic [23:0] wq[$];
   logic [15:0] rq[$];
   logic [7:0] aq[$], xq[$];

   cspr_core_regs dut (.core_clk(core_clk), .sys_rst(sys_rst), .req(req),
      .mem_rdata(mem_rdata), .mem(mem), .stack_pointer(stack_pointer),
      .program_counter(program_counter), .condition_flags_reg(condition_flags_reg),
      .acc_out(acc_out), .acc_valid(acc_valid), .idx_out(idx_out),
      .idx_valid(idx_valid), .busy(busy));

   initial forever #20 core_clk = ~core_clk;

   // Memory answers in the cycle after a read strobe, scrambles the bus otherwise
   always @(negedge core_clk) begin
      if (rd_seen) mem_rdata <= ram[rd_addr];
      else mem_rdata <= ~mem_rdata;
      rd_seen <= (mem.rd === 1'b1);
      rd_addr <= mem.addr;
   end

   // Result watcher: each strobe or pulse takes the oldest note
   always @(posedge core_clk) if (!sys_rst) begin
      if (mem.wr === 1'b1) begin
         ram[mem.addr] <= mem.wdata;
         e24 = wq.size() ? wq.pop_front() : 24'hx;
         `CSPR_CHK({mem.addr, mem.wdata}, e24)
      end
      if (mem.rd === 1'b1) begin
         e16 = rq.size() ? rq.pop_front() : 16'hx;
         `CSPR_CHK(mem.addr, e16)
      end
      if (acc_valid === 1'b1) begin
         e8 = aq.size() ? aq.pop_front() : 8'hx;
         `CSPR_CHK(acc_out, e8)
      end
      if (idx_valid === 1'b1) begin
         x8 = xq.size() ? xq.pop_front() : 8'hx;
         `CSPR_CHK(idx_out, x8)
      end
   end

   // Hold the strobes for one edge, then wait for busy to drop (back in ST_RUN)
   task automatic go();
      @(negedge core_clk);
      {req.fetch, req.load, req.adjust, req.low_reload, req.irq_entry, req.irq_return,
         req.ccr_wr} = '0;
      for (int n = 0; n < 40 && busy !== 1'b0; n++) @(negedge core_clk);
      `CSPR_CHK(busy, 1'b0)
   endtask

   task automatic end_of_test();
      if (fail_count == 0 && samples_checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   initial begin
      repeat (3000) @(posedge core_clk);
      fail_count++;
      end_of_test();
   end

   // Main sequence
   initial begin
      v = 8'($urandom(40));
      req = '0;
      mem_rdata = 8'h00;
      rd_seen = 1'b0;
      foreach (ram[i]) ram[i] = 8'($urandom);
      pc = {ram[16'hfffe], ram[16'hffff]};
      rq.push_back(16'hfffe);
      rq.push_back(16'hffff);
      repeat (5) @(negedge core_clk);
      `CSPR_CHK(stack_pointer, `CSPR_SP_RESET)
      sys_rst = 1'b0;
      go();
      `CSPR_CHK(program_counter, pc)
      sp = 16'h00ff;
      // Jump to the top of memory, fetch across the wrap, then jump again
      for (int i = 0; i < 6; i++) begin
         req.fetch = 1'b1;
         req.load = (i == 0 || i == 5);
         req.target = (i == 0) ? 16'hfffe : 16'($urandom);
         pc = req.load ? req.target : pc + 16'h1;
         go();
         `CSPR_CHK(program_counter, pc)
      end
      foreach (v_tab[i]) begin
         req.adjust = 1'b1;
         req.adjust_imm = v_tab[i];
         sp = sp + {{8{v_tab[i][7]}}, v_tab[i]};
         go();
         `CSPR_CHK(stack_pointer, sp)
      end
      req.low_reload = 1'b1;
      sp[7:0] = `CSPR_SPL_RELOAD;
      go();
      `CSPR_CHK(stack_pointer, sp)
      for (int i = 0; i < 2; i++) begin
         v = i ? 8'($urandom) : 8'h00;
         req.ccr_wr = 1'b1;
         req.ccr_in = v;
         go();
         `CSPR_CHK(condition_flags_reg, v | `CSPR_CCR_ONES)
      end
      // Interrupt entry pushes five bytes downwards
      req.acc_in = 8'($urandom);
      req.idx_in = 8'($urandom);
      wq = '{{sp, pc[7:0]}, {sp - 16'h1, pc[15:8]}, {sp - 16'h2, req.idx_in},
         {sp - 16'h3, req.acc_in}, {sp - 16'h4, v | `CSPR_CCR_ONES}};
      req.irq_entry = 1'b1;
      req.isr_addr = 16'($urandom);
      go();
      sp = sp - 16'h5;
      `CSPR_CHK(stack_pointer, sp)
      `CSPR_CHK(program_counter, req.isr_addr)
      // Let the last push land before the stack is refilled
      @(negedge core_clk);
      // Fresh stack contents so the return proves where each byte lands
      for (int i = 1; i <= 5; i++) begin
         ram[sp + 16'(i)] = 8'($urandom);
         rq.push_back(sp + 16'(i));
      end
      aq.push_back(ram[sp + 16'h2]);
      xq.push_back(ram[sp + 16'h3]);
      pc = {ram[sp + 16'h4], ram[sp + 16'h5]};
      v = ram[sp + 16'h1];
      req.irq_return = 1'b1;
      go();
      sp = sp + 16'h5;
      `CSPR_CHK(stack_pointer, sp)
      `CSPR_CHK(program_counter, pc)
      `CSPR_CHK(condition_flags_reg, v | `CSPR_CCR_ONES)
      repeat (3) @(negedge core_clk);
      `CSPR_CHK(wq.size() + rq.size() + aq.size() + xq.size(), 0)
      end_of_test();
   end

endmodule
`default_nettype wire
